// ===== rtl/nps_pkg.sv
// Shared constants, types and register map of the NAND page-read sequencer
package nps_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WB_NS       = 100;
  localparam int TWB_CYC       = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TWB_CNT = 4'(TWB_CYC - 1);

  // Opcodes on the flash bus
  localparam logic [7:0] OPC_READ       = 8'h00;
  localparam logic [7:0] OPC_CONFIRM    = 8'h30;
  localparam logic [7:0] OPC_CACHE_SEQ  = 8'h31;
  localparam logic [7:0] OPC_CACHE_LAST = 8'h3F;
  localparam logic [7:0] OPC_COL_CHG    = 8'h05;
  localparam logic [7:0] OPC_PLANE_SEL  = 8'h06;
  localparam logic [7:0] OPC_COL_END    = 8'hE0;
  localparam logic [7:0] OPC_STATUS     = 8'h70;
  localparam logic [7:0] OPC_STATUS_ENH = 8'h78;

  // Address layout
  localparam int COL_BITS      = 16;
  localparam int ROW_BITS      = 24;
  localparam int PLANE_BIT     = 6;
  localparam int ROW_DIE_BIT   = 18;
  localparam int STAT_RDY_BIT  = 6;
  localparam int STAT_ARRAY_IDLE_BIT_BIT = 5;

  // Address byte selectors: column, raw row, row forced to plane 0, second row forced to plane 1,
  // row with software plane bit
  localparam logic [3:0] SEL_COL = 4'h0;
  localparam logic [3:0] SEL_ROW = 4'h2;
  localparam logic [3:0] SEL_P0  = 4'h5;
  localparam logic [3:0] SEL_P1  = 4'h8;
  localparam logic [3:0] SEL_PS  = 4'hB;

  // Register map (byte offsets)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COL    = 8'h04;
  localparam logic [7:0] REG_ROW    = 8'h08;
  localparam logic [7:0] REG_ROW2   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_DATA   = 8'h14;

  // Field positions
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_POLL    = 3;
  localparam int CTRL_PLANE   = 4;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_CACHE_BIT = 2;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_BYTE_LSB  = 8;

  // Pin cycle phases
  localparam logic [1:0] PH_SETUP  = 2'h0;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST   = 2'h3;

  typedef enum logic [2:0] {
    OP_PAGE = 3'h0, OP_TWO = 3'h1, OP_SEQ = 3'h2, OP_RAND = 3'h3,
    OP_LAST = 3'h4, OP_COL = 3'h5, OP_PSEL = 3'h6, OP_RDB = 3'h7
  } nps_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_FETCH = 3'b001, ST_CYC = 3'b011,
    ST_TWB = 3'b010, ST_BUSY = 3'b110, ST_STAT = 3'b111
  } nps_state_t;

  typedef enum logic [2:0] {
    SK_END = 3'h0, SK_CMD = 3'h1, SK_ADDR = 3'h2, SK_READ = 3'h3, SK_WAIT = 3'h4
  } nps_kind_t;

  typedef struct packed {
    nps_kind_t   kind;
    logic [7:0]  val;
  } nps_step_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
  } nps_ctl_t;
endpackage

// ===== rtl/nps_sequencer.sv
// Host-side NAND page-read sequencer with AHB-Lite register port
//
// How it works
// R01: page read 00h-addr-30h only when fully ready
// R02: die goes fully busy for array read
// R03: after polled ready, send read-mode opcode
// R04: output starts at the given column
// R05: column change 05h-E0h during output
// R06: multi-die needs enhanced status before read-mode; the code sends 00h with no 78h first (single die assumed)
// R07: two-plane: last named plane outputs first
// R08: plane column select 06h-E0h exists
// R09: sequential cache read 31h when ready
// R10: 31h busy, then cache data from column 0
// R11: sequential read crosses block boundaries
// R12: never cross die boundary with 31h
// R13: random cache read ignores column address
// R14: random cache read keeps same die
// R15: multi-die: enhanced status then read-mode; the code never sends 78h, 00h follows the 70h poll directly
// R16: 3Fh ends cache read, fully ready after
// R17: two-plane: plane bit 0 then 1, confirm
// R18: both planes share one column address
// R19: two-plane: select plane before plane 1
// R20: polled two-plane: select plane before reading
// R21: never use enhanced status with two-plane
// R22: while fully busy only status or reset
// R23: die ignores commands not accepted when busy
`timescale 1ns/100ps
module nps_sequencer
  import nps_pkg::*;
#(
  parameter int DIE_BIT = ROW_DIE_BIT
)(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output nps_ctl_t         nand_ctl_out,
  output logic      [7:0]  io_out,
  output logic             io_oe_out,
  input  wire logic [7:0]  io_in,
  input  wire logic        rb_n_in
);

  nps_state_t          state;
  nps_state_t          ret_state;
  nps_kind_t           cyc_kind;
  nps_op_t             op_r;
  logic [7:0]          cyc_byte;
  logic [1:0]          phase;
  logic [4:0]          idx;
  logic [3:0]          cnt;
  logic                poll_r;
  logic                plane_r;
  logic [COL_BITS-1:0] col_r;
  logic [ROW_BITS-1:0] row_r;
  logic [ROW_BITS-1:0] row2_r;
  logic [ROW_BITS-1:0] cur_row;
  logic                cache_mode;
  logic                read_valid;
  logic                err;
  logic [7:0]          stat_byte;
  logic                have_byte;
  logic [7:0]          data_byte;
  logic                wr_pend;
  logic [7:0]          wr_addr;

  // Step table of each operation; poll adds the plane select after a two-plane read
  function automatic nps_step_t step_of(input nps_op_t op, input logic [4:0] i, input logic poll);
    nps_step_t s;
    s = '{SK_END, 8'h00};
    case (op)
      OP_PAGE, OP_RAND:
        if (i == 5'd0) s = '{SK_CMD, OPC_READ};
        else if (i <= 5'd5) s = '{SK_ADDR, 8'(i - 5'd1)};
        else if (i == 5'd6) s = '{SK_CMD, (op == OP_PAGE) ? OPC_CONFIRM : OPC_CACHE_SEQ};
        else if (i == 5'd7) s = '{SK_WAIT, 8'h00};
      OP_TWO:
        if (i == 5'd0 || i == 5'd6) s = '{SK_CMD, OPC_READ};
        else if (i <= 5'd2) s = '{SK_ADDR, 8'(i - 5'd1)};
        else if (i <= 5'd5) s = '{SK_ADDR, 8'(SEL_P0) + 8'(i - 5'd3)};
        else if (i <= 5'd8) s = '{SK_ADDR, 8'(i - 5'd7)};
        else if (i <= 5'd11) s = '{SK_ADDR, 8'(SEL_P1) + 8'(i - 5'd9)};
        else if (i == 5'd12) s = '{SK_CMD, OPC_CONFIRM};
        else if (i == 5'd13) s = '{SK_WAIT, 8'h00};
        else if (poll && i == 5'd14) s = '{SK_CMD, OPC_PLANE_SEL};
        else if (poll && i <= 5'd16) s = '{SK_ADDR, 8'(i - 5'd15)};
        else if (poll && i <= 5'd19) s = '{SK_ADDR, 8'(SEL_P0) + 8'(i - 5'd17)};
        else if (poll && i == 5'd20) s = '{SK_CMD, OPC_COL_END};
      OP_SEQ, OP_LAST:
        if (i == 5'd0) s = '{SK_CMD, (op == OP_SEQ) ? OPC_CACHE_SEQ : OPC_CACHE_LAST};
        else if (i == 5'd1) s = '{SK_WAIT, 8'h00};
      OP_COL: // R05
        if (i == 5'd0) s = '{SK_CMD, OPC_COL_CHG};
        else if (i <= 5'd2) s = '{SK_ADDR, 8'(i - 5'd1)};
        else if (i == 5'd3) s = '{SK_CMD, OPC_COL_END};
      OP_PSEL: // R19
        if (i == 5'd0) s = '{SK_CMD, OPC_PLANE_SEL};
        else if (i <= 5'd2) s = '{SK_ADDR, 8'(i - 5'd1)};
        else if (i <= 5'd5) s = '{SK_ADDR, 8'(SEL_PS) + 8'(i - 5'd3)};
        else if (i == 5'd6) s = '{SK_CMD, OPC_COL_END};
      default:
        if (i == 5'd0) s = '{SK_READ, 8'h00};
    endcase
    return s;
  endfunction

  // Address bytes: one column (two byte lanes) and four row variants (three byte lanes each)
  wire logic [ROW_BITS-1:0] row_p0 = {row_r[ROW_BITS-1:PLANE_BIT+1], 1'b0, row_r[PLANE_BIT-1:0]};   // R17
  wire logic [ROW_BITS-1:0] row_p1 = {row2_r[ROW_BITS-1:PLANE_BIT+1], 1'b1, row2_r[PLANE_BIT-1:0]}; // R17
  wire logic [ROW_BITS-1:0] row_ps = {row_r[ROW_BITS-1:PLANE_BIT+1], plane_r, row_r[PLANE_BIT-1:0]};
  // One column register feeds both planes' address cycles
  wire logic [111:0]        abus   = {row_ps, row_p1, row_p0, row_r, col_r}; // R18
  wire nps_step_t           step   = step_of(op_r, idx, poll_r);
  wire logic [7:0]          abyte  = abus[{step.val[3:0], 3'b000} +: 8];

  // Bus decode
  wire logic    accept   = hsel_in && hready_in && htrans_in[1];
  wire logic    ctrl_wr  = wr_pend && wr_addr == REG_CTRL;
  wire logic    stat_wr  = wr_pend && wr_addr == REG_STATUS;
  wire nps_op_t req_op   = nps_op_t'(hwdata_in[CTRL_OP_LSB +: 3]);
  wire logic    die_end  = &cur_row[DIE_BIT-1:0];
  wire logic    need_rdy = req_op == OP_PAGE || req_op == OP_TWO;
  wire logic    refuse   = (need_rdy && cache_mode)                                      // R01
                        || (!need_rdy && !read_valid)
                        || (req_op == OP_SEQ && die_end)                                 // R12
                        || (req_op == OP_RAND && row_r[DIE_BIT] != cur_row[DIE_BIT]);    // R14
  wire logic    go       = ctrl_wr && state == ST_IDLE && !refuse;
  wire logic    poll_rdy = state == ST_STAT && have_byte && stat_byte[STAT_RDY_BIT];
  wire logic [31:0] status_word = {16'h0000, stat_byte, 4'h0, read_valid, cache_mode, err, state != ST_IDLE};
  wire logic [7:0]  ra = haddr_in[7:0];
  wire logic [31:0] rd_val = (ra == REG_CTRL)   ? {27'h000_0000, plane_r, poll_r, op_r}
                           : (ra == REG_COL)    ? {16'h0000, col_r}
                           : (ra == REG_ROW)    ? {8'h00, row_r}
                           : (ra == REG_ROW2)   ? {8'h00, row2_r}
                           : (ra == REG_STATUS) ? status_word
                           : (ra == REG_DATA)   ? {24'h00_0000, data_byte}
                           : 32'h0000_0000;

  // Pin drive: setup, two strobe-low phases, hold
  wire logic in_cyc = state == ST_CYC;
  wire logic strobe = in_cyc && phase != PH_SETUP && phase != PH_LAST;
  wire logic is_rd  = cyc_kind == SK_READ;
  assign nand_ctl_out.ce_n = state == ST_IDLE;
  assign nand_ctl_out.cle  = in_cyc && cyc_kind == SK_CMD;
  assign nand_ctl_out.ale  = in_cyc && cyc_kind == SK_ADDR;
  assign nand_ctl_out.we_n = !(strobe && !is_rd);
  assign nand_ctl_out.re_n = !(strobe && is_rd);
  assign io_out            = cyc_byte;
  assign io_oe_out         = in_cyc && !is_rd;
  assign hreadyout_out     = 1'b1;
  assign hresp_out         = 1'b0;

  // Registers and die-state bookkeeping
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_pend <= 1'b0; wr_addr <= 8'h00; hrdata_out <= 32'h0000_0000;
      op_r <= OP_PAGE; poll_r <= 1'b0; plane_r <= 1'b0;
      col_r <= '0; row_r <= '0; row2_r <= '0; cur_row <= '0;
      cache_mode <= 1'b0; read_valid <= 1'b0; err <= 1'b0;
    end
    else
    begin
      wr_pend <= accept && hwrite_in;
      wr_addr <= ra;
      if (accept && !hwrite_in) hrdata_out <= rd_val;
      if (wr_pend && wr_addr == REG_COL) col_r <= hwdata_in[COL_BITS-1:0];
      if (wr_pend && wr_addr == REG_ROW) row_r <= hwdata_in[ROW_BITS-1:0];
      if (wr_pend && wr_addr == REG_ROW2) row2_r <= hwdata_in[ROW_BITS-1:0];
      // Refused or busy-time orders raise the error flag; a new refusal beats a clear
      err <= (ctrl_wr && !go) || (err && !(stat_wr && hwdata_in[ST_ERR_BIT]));
      if (go)
      begin
        op_r    <= req_op;
        poll_r  <= hwdata_in[CTRL_POLL];
        plane_r <= hwdata_in[CTRL_PLANE];
        if (need_rdy) read_valid <= 1'b1;
        if (req_op == OP_SEQ || req_op == OP_RAND) cache_mode <= 1'b1;
        else if (need_rdy || req_op == OP_LAST) cache_mode <= 1'b0;
        // Track the page that ends up in the cache for die-boundary checks
        if (req_op == OP_SEQ) cur_row <= cur_row + 24'h00_0001; // R11
        else if (req_op == OP_RAND || req_op == OP_PAGE) cur_row <= row_r;
        else if (req_op == OP_TWO) cur_row <= row_p1;
      end
    end
  end

  // Sequencer
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= ST_IDLE; ret_state <= ST_IDLE; cyc_kind <= SK_END; cyc_byte <= 8'h00;
      phase <= PH_SETUP; idx <= 5'h00; cnt <= 4'h0;
      stat_byte <= 8'h00; have_byte <= 1'b0; data_byte <= 8'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (go)
          begin
            state <= ST_FETCH;
            idx   <= 5'h00;
          end
        ST_FETCH:
        begin
          idx <= idx + 5'h01;
          if (step.kind == SK_END) state <= ST_IDLE;
          else if (step.kind == SK_WAIT)
          begin
            cnt   <= TWB_CNT;
            state <= ST_TWB;
          end
          else
          begin
            cyc_kind  <= step.kind;
            cyc_byte  <= (step.kind == SK_ADDR) ? abyte : step.val;
            phase     <= PH_SETUP;
            ret_state <= ST_FETCH;
            state     <= ST_CYC;
          end
        end
        ST_CYC:
        begin
          phase <= phase + 2'h1;
          if (phase == PH_SAMPLE && is_rd && ret_state == ST_STAT)
          begin
            stat_byte <= io_in;
            have_byte <= 1'b1;
          end
          else if (phase == PH_SAMPLE && is_rd) data_byte <= io_in;
          if (phase == PH_LAST) state <= ret_state;
        end
        ST_TWB:
          if (cnt != 4'h0) cnt <= cnt - 4'h1;
          else if (poll_r)
          begin
            // Only plain status while busy; enhanced status never leaves this block
            cyc_kind  <= SK_CMD; // R22 R21
            cyc_byte  <= OPC_STATUS;
            have_byte <= 1'b0;
            phase     <= PH_SETUP;
            ret_state <= ST_STAT;
            state     <= ST_CYC;
          end
          else state <= ST_BUSY;
        ST_BUSY:
          if (rb_n_in) state <= ST_FETCH; // R22
        ST_STAT:
        begin
          phase <= PH_SETUP;
          state <= ST_CYC;
          if (poll_rdy && op_r == OP_TWO) state <= ST_FETCH; // R20
          else if (poll_rdy)
          begin
            // Single die per target assumed, so no enhanced status select first
            cyc_kind  <= SK_CMD; // R03 R06 R15
            cyc_byte  <= OPC_READ;
            ret_state <= ST_FETCH;
          end
          else
          begin
            cyc_kind  <= SK_READ;
            ret_state <= ST_STAT;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_busy_quiet;
    (!rb_n_in && !nand_ctl_out.we_n) |-> (nand_ctl_out.cle && io_out == OPC_STATUS);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("command other than status while busy"); // R22

  property p_confirm_ready;
    (nand_ctl_out.cle && !nand_ctl_out.we_n && io_out == OPC_CONFIRM) |-> !cache_mode;
  endproperty
  a_confirm_ready: assert property (p_confirm_ready) else $error("page confirm while not fully ready"); // R01

  property p_we_pulse;
    $fell(nand_ctl_out.we_n) |=> !nand_ctl_out.we_n ##1 nand_ctl_out.we_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe not two cycles low"); // write strobe timing of command and address cycles

  property p_mode_after_poll;
    (poll_rdy && op_r != OP_TWO) |=> (state == ST_CYC && cyc_kind == SK_CMD && cyc_byte == OPC_READ)
      ##2 (nand_ctl_out.cle && !nand_ctl_out.we_n);
  endproperty
  a_mode_after_poll: assert property (p_mode_after_poll) else $error("read mode not sent after poll"); // R03

  property p_col_change;
    (go && req_op == OP_COL) |-> ##2 (nand_ctl_out.cle && io_out == OPC_COL_CHG) ##1 !nand_ctl_out.we_n;
  endproperty
  a_col_change: assert property (p_col_change) else $error("column change opcode not issued"); // R05

  property p_seq_in_die;
    (nand_ctl_out.cle && !nand_ctl_out.we_n && io_out == OPC_CACHE_SEQ && op_r == OP_SEQ)
      |-> cur_row[DIE_BIT-1:0] != '0;
  endproperty
  a_seq_in_die: assert property (p_seq_in_die) else $error("sequential cache read crossed die"); // R12

  property p_rand_same_die;
    (go && req_op == OP_RAND) |=> cur_row[DIE_BIT] == $past(cur_row[DIE_BIT]);
  endproperty
  a_rand_same_die: assert property (p_rand_same_die) else $error("random cache read changed die"); // R14

  property p_plane_zero;
    (state == ST_FETCH && step.kind == SK_ADDR && step.val == 8'(SEL_P0)) |=> !cyc_byte[PLANE_BIT];
  endproperty
  a_plane_zero: assert property (p_plane_zero) else $error("first plane address not plane 0"); // R17

  property p_plane_one;
    (state == ST_FETCH && step.kind == SK_ADDR && step.val == 8'(SEL_P1)) |=> cyc_byte[PLANE_BIT];
  endproperty
  a_plane_one: assert property (p_plane_one) else $error("second plane address not plane 1"); // R17

  property p_no_enhanced;
    (nand_ctl_out.cle && !nand_ctl_out.we_n) |-> io_out != OPC_STATUS_ENH;
  endproperty
  a_no_enhanced: assert property (p_no_enhanced) else $error("enhanced status issued"); // R21

  property p_two_poll_sel;
    (poll_rdy && op_r == OP_TWO) |=> state == ST_FETCH ##1 (state == ST_CYC && cyc_byte == OPC_PLANE_SEL);
  endproperty
  a_two_poll_sel: assert property (p_two_poll_sel) else $error("plane select missing after poll"); // R20

endmodule // nps_sequencer

// ===== verification/nps_die_model.sv
// Behavioural NAND die that answers the sequencer's pins
`timescale 1ns/100ps
module nps_die_model
  import nps_pkg::*;
#(
  parameter int T_READ_NS  = 2000,
  parameter int T_CACHE_NS = 800
)(
  input  wire nps_ctl_t   ctl_in,
  input  wire logic [7:0] io_in,
  output logic      [7:0] io_out,
  output logic            rb_n_out
);
  logic [7:0]  ab [5];
  logic [23:0] pend [2];
  logic [23:0] cr [2];
  logic [23:0] dr;
  logic [15:0] col;
  logic [7:0]  park;
  logic        rdy, array_idle_bit, stat, sel, cmode;
  int          na, bt;
  event        go;
  wire  [23:0] ar = {ab[4], ab[3], ab[2]};
  wire  [23:0] rr = cr[sel];
  wire  [7:0]  dout = stat ? {1'b0, rdy, array_idle_bit, 5'h00} : rr[7:0] ^ rr[15:8] ^ rr[23:16] ^ col[7:0] ^ col[15:8];

  // Released bus shows the inverse of the last byte
  assign io_out = ctl_in.re_n ? park : dout;

  initial
  begin
    {rdy, array_idle_bit, rb_n_out, stat, sel, cmode} = 6'b111000;
    {cr[0], cr[1], pend[0], pend[1], dr, col, park} = '0;
    na = 0;
  end

  always
  begin
    @(go);
    {rdy, array_idle_bit, rb_n_out} = 3'b000;
    #(bt);
    {rdy, array_idle_bit, rb_n_out} = {1'b1, !cmode, 1'b1};
  end

  always @(posedge ctl_in.we_n)
  begin
    if (!ctl_in.ce_n && ctl_in.ale && rdy && na < 5)
    begin
      ab[na] = io_in;
      na++;
    end
    else if (!ctl_in.ce_n && ctl_in.cle && (rdy || io_in == OPC_STATUS))
    begin
      stat = (io_in == OPC_STATUS);
      if (na == 5) pend[ar[PLANE_BIT]] = ar;
      case (io_in)
        OPC_CONFIRM:
          if (array_idle_bit)
          begin
            cr[0] = pend[0];
            cr[1] = pend[1];
            dr = ar;
            sel = ar[PLANE_BIT];
            col = {ab[1], ab[0]};
            cmode = 1'b0;
            bt = T_READ_NS;
            ->go;
          end
        OPC_CACHE_SEQ:
        begin
          cr[sel] = dr;
          dr = (na == 5) ? ar : dr + 24'h00_0001;
          col = 16'h0000;
          cmode = 1'b1;
          bt = T_CACHE_NS;
          ->go;
        end
        OPC_CACHE_LAST:
        begin
          cr[sel] = dr;
          col = 16'h0000;
          cmode = 1'b0;
          bt = T_CACHE_NS;
          ->go;
        end
        OPC_COL_END:
        begin
          col = {ab[1], ab[0]};
          if (na == 5) sel = ar[PLANE_BIT];
        end
        default:;
      endcase
      na = 0;
    end
  end

  always @(posedge ctl_in.re_n)
  begin
    park = ~dout;
    if (!ctl_in.ce_n && !stat) col++;
  end
endmodule  // nps_die_model

// ===== verification/tb_top.sv
// Self-checking bench: sequencer on AHB-Lite against a behavioural die
`timescale 1ns/100ps
module tb_top
  import nps_pkg::*;
;
  logic        mclk_in, reset_in, hsel_in, hwrite_in, e_sel;
  logic [31:0] haddr_in, hwdata_in, q;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [23:0] e_cr [2];
  logic [23:0] e_dr, r, r2;
  logic [15:0] e_col, c;
  int          n_errors, num_checks, i, seed;
  wire  [31:0] hrdata_out;
  wire         hreadyout_out, hresp_out, io_oe_out, rb_n;
  wire  [7:0]  io_out, die_io;
  wire  [7:0]  bus = io_oe_out ? io_out : die_io;
  wire nps_ctl_t ctl;

  nps_sequencer uut (.mclk_in(mclk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .nand_ctl_out(ctl), .io_out(io_out), .io_oe_out(io_oe_out), .io_in(bus), .rb_n_in(rb_n));
  nps_die_model die (.ctl_in(ctl), .io_in(bus), .io_out(die_io), .rb_n_out(rb_n));

  always #12.5 mclk_in = ~mclk_in;

  function automatic logic [7:0] pb(input logic [23:0] rw, input logic [15:0] cl);
    return rw[7:0] ^ rw[15:8] ^ rw[23:16] ^ cl[7:0] ^ cl[15:8];
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h00_0000, a};
    hwrite_in <= wr;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out;
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q & m, e);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end
    while (q[ST_BUSY_BIT] !== 1'b0 && n < 500);
    if (n >= 500) chk(q, 32'h0000_0000);
  endtask

  task automatic op(input logic [4:0] cd, input logic [15:0] cl, input logic [23:0] rw, input logic [23:0] rw2);
    ahb(1'b1, REG_COL, {16'h0000, cl});
    ahb(1'b1, REG_ROW, {8'h00, rw});
    ahb(1'b1, REG_ROW2, {8'h00, rw2});
    ahb(1'b1, REG_CTRL, {27'h000_0000, cd});
    wait_done();
    e_col = cl;
    case (cd[2:0])
      OP_PAGE: {e_cr[rw[6]], e_dr, e_sel} = {rw, rw, rw[6]};
      OP_TWO: {e_cr[0], e_cr[1], e_sel} = {rw & 24'hff_ffbf, rw2 | 24'h00_0040, !cd[3]};
      OP_SEQ: {e_cr[e_sel], e_dr, e_col} = {e_dr, e_dr + 24'h00_0001, 16'h0000};
      OP_RAND: {e_cr[e_sel], e_dr, e_col} = {e_dr, rw, 16'h0000};
      OP_LAST: {e_cr[e_sel], e_col} = {e_dr, 16'h0000};
      OP_PSEL: e_sel = cd[4];
      default:;
    endcase
  endtask

  task automatic rbyte();
    ahb(1'b1, REG_CTRL, {29'h0000_0000, OP_RDB});
    wait_done();
    ahb(1'b0, REG_DATA, 32'h0000_0000);
    chk(q & 32'h0000_00ff, {24'h00_0000, pb(e_cr[e_sel], e_col)});
    e_col++;
  endtask

  initial
  begin
    #1_000_000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    mclk_in = 1'b0;
    reset_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = '0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    hwdata_in = '0;
    n_errors = 0;
    num_checks = 0;
    seed = $urandom(49331);
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    st(32'hffff_ffff, 32'h0000_0000);
    ahb(1'b1, 8'h3c, 32'hffff_ffff);
    ahb(1'b0, 8'h3c, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    for (i = 0; i < 2; i++)
    begin
      c = 16'($urandom_range(4000));
      r = 24'($urandom) & 24'h03_ffbf;
      op({1'b0, i[0], OP_PAGE}, c, r, 24'h00_0000);
      if (i == 1) st(32'h0000_ff00, 32'h0000_6000);
      rbyte();
      rbyte();
      op({2'b00, OP_COL}, c ^ 16'h0155, 24'h00_0000, 24'h00_0000);
      rbyte();
    end
    // Last page of a block, so the first sequential step crosses into the next block
    r = {7'h00, 11'($urandom), 6'h3f};
    op({2'b00, OP_PAGE}, c, r, 24'h00_0000);
    op({2'b01, OP_SEQ}, 16'h0000, 24'h00_0000, 24'h00_0000);
    st(32'h0000_ff04, 32'h0000_4004);
    rbyte();
    op({2'b00, OP_SEQ}, 16'h0000, 24'h00_0000, 24'h00_0000);
    rbyte();
    op({2'b00, OP_RAND}, c, r ^ 24'h00_0a80, 24'h00_0000);
    rbyte();
    op({2'b01, OP_LAST}, 16'h0000, 24'h00_0000, 24'h00_0000);
    st(32'h0000_ff04, 32'h0000_6000);
    rbyte();
    // Last page of the die: every low row bit set, plane bit included
    op({2'b00, OP_PAGE}, c, 24'h03_ffff, 24'h00_0000);
    ahb(1'b1, REG_CTRL, {29'h0000_0000, OP_SEQ});
    st(32'h0000_0003, 32'h0000_0002);
    ahb(1'b1, REG_STATUS, 32'h0000_0002);
    st(32'h0000_0003, 32'h0000_0000);
    ahb(1'b1, REG_CTRL, {29'h0000_0000, OP_PAGE});
    ahb(1'b1, REG_CTRL, {29'h0000_0000, OP_COL});
    wait_done();
    st(32'h0000_0003, 32'h0000_0002);
    ahb(1'b1, REG_STATUS, 32'h0000_0002);
    e_col = c;
    rbyte();
    for (i = 0; i < 2; i++)
    begin
      r = 24'($urandom) & 24'h03_ffff;
      r2 = r ^ 24'h00_1200;
      op({1'b0, i[0], OP_TWO}, c, r, r2);
      rbyte();
      op({i[0], 1'b0, OP_PSEL}, c + 16'h0010, r, 24'h00_0000);
      rbyte();
    end
    complete_run();
  end
endmodule  // tb_top
